// File: lpcaf_ctrl_model.sv
// Behavioural memory controller driving the command, address and write data pins.
`default_nettype none
module lpcaf_ctrl_model
	import lpcaf_pkg::*;
(
	input wire logic i_clock,
	output logic [CA_W-1:0] o_ca_rise,
	output logic [CA_W-1:0] o_ca_fall,
	output logic o_cs_n,
	output logic o_cke,
	output logic [DATA_W-1:0] o_wdata,
	output logic [MASK_W-1:0] o_wmask
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_ca_rise = '0;
		o_ca_fall = '0;
		o_cs_n = 1'b1;
		o_cke = 1'b1;
		o_wdata = '0;
		o_wmask = '0;
	end
	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// Deselected lines are inverted so that a stale command never looks valid.
	task automatic cmd(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
		@(posedge i_clock);
		o_cs_n <= 1'b0;
		o_ca_rise <= r;
		o_ca_fall <= f;
		@(posedge i_clock);
		o_cs_n <= 1'b1;
		o_ca_rise <= ~r;
		o_ca_fall <= ~f;
	endtask
	// Beat zero goes out lat+1 edges after the command edge, lat after the deselect edge, matching the two-flop input delay; lat is at least one.
	task automatic wr_data(input int lat, input int n, input logic [DATA_W-1:0] d [16], input logic [MASK_W-1:0] m);
		repeat (lat) @(posedge i_clock);
		for (int k = 0; k < n; k++) begin
			o_wdata <= d[k];
			o_wmask <= m;
			@(posedge i_clock);
		end
		o_wdata <= ~d[n-1];
		o_wmask <= ~m;
	endtask
	// The clock never stops here; only the clock enable drops, and only while idle.
	task automatic set_cke(input logic v);
		@(posedge i_clock);
		o_cke <= v;
	endtask
endmodule
`default_nettype wire

// File: lpcaf_mem.sv
// Array model with per-byte write enables and registered read data.
`default_nettype none
module lpcaf_mem
	import lpcaf_pkg::*;
(
	input wire logic i_clock,
	lpcaf_mem_if.mem bus
);
	logic [DATA_W-1:0] q;

	// Each byte lane is its own array, so one process owns it and a masked lane keeps its old contents.
	for (genvar b = 0; b < MASK_W; b++) begin : g_lane
		logic [7:0] lane [0:(1<<MEM_AW)-1];
		always_ff @(posedge i_clock) begin
			if (bus.we && bus.be[b]) begin
				lane[bus.addr] <= bus.wdata[8*b +: 8];
			end
			if (bus.re) begin
				q[8*b +: 8] <= lane[bus.addr];
			end
		end
	end

	assign bus.rdata = q;
endmodule
`default_nettype wire

// File: lpcaf_mem_if.sv
// Connection between the burst sequencer and the array model.
`default_nettype none
interface lpcaf_mem_if;
	import lpcaf_pkg::*;
	logic we;
	logic re;
	logic [MASK_W-1:0] be;
	logic [MEM_AW-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	modport ctrl (output we, output re, output be, output addr, output wdata, input rdata);
	modport mem (input we, input re, input be, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: lpcaf_pkg.sv
// Constants, encodings and types shared by the command/address front end.
`default_nettype none
package lpcaf_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int CA_W = 10;
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ROW_W = 15;
	localparam int COL_W = 9;
	localparam int DATA_W = 32;
	localparam int MASK_W = 4;
	localparam int MEM_AW = 8;
	localparam int LAT_W = 4;
	localparam int BEAT_W = 5;
	localparam int RADDR_W = 4;
	// ----------------------------------------------------------------
	// Command codes on the rising-edge half of the bus
	// ----------------------------------------------------------------
	localparam logic [1:0] ACT_CODE = 2'h2;
	localparam logic [2:0] WR_CODE = 3'h1;
	localparam logic [2:0] RD_CODE = 3'h5;
	localparam logic [3:0] PRE_CODE = 4'hB;
	localparam logic [3:0] REFAB_CODE = 4'h7;
	localparam logic [3:0] REFPB_CODE = 4'h3;
	// ----------------------------------------------------------------
	// Field positions on the bus
	// ----------------------------------------------------------------
	localparam int BANK_LSB = 7;
	localparam int ROW_HI_LSB = 2;
	localparam int PRE_ALL_BIT = 4;
	localparam int AP_BIT = 0;
	localparam int COL_LSB = 1;
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	localparam logic [RADDR_W-1:0] REG_CFG = 4'h0;
	localparam logic [RADDR_W-1:0] REG_PASR = 4'h4;
	localparam logic [RADDR_W-1:0] REG_STATUS = 4'h8;
	localparam int CFG_BL_LSB = 0;
	localparam int CFG_RL_LSB = 2;
	localparam int CFG_WL_LSB = 6;
	localparam int CFG_X16_BIT = 10;
	localparam int STAT_IDLE_BIT = 4;
	localparam int STAT_ILL_BIT = 5;
	localparam logic [10:0] CFG_RST = 11'h0C4;
	localparam logic [3:0] PASR_RST = 4'h0;
	localparam logic [1:0] BL8_CODE = 2'h1;
	localparam logic [1:0] BL16_CODE = 2'h2;
	localparam logic [BEAT_W-1:0] BL4_BEATS = 5'h04;
	localparam logic [BEAT_W-1:0] BL8_BEATS = 5'h08;
	localparam logic [BEAT_W-1:0] BL16_BEATS = 5'h10;
	localparam logic [1:0] PREFETCH_MASK = 2'h3;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int SREF_INTERVAL_NS = 3900;
	localparam int SREF_CYC = SREF_INTERVAL_NS / CLK_PERIOD_NS;
	localparam int SREF_CNT_W = 10;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WAIT = 3'h2,
		ST_DATA = 3'h4
	} lpcaf_state_t;
endpackage
`default_nettype wire

// File: lpcaf_top.sv
// Command/address front end: decode, bank state, burst sequencer, registers.
`default_nettype none
module lpcaf_top
	import lpcaf_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic [CA_W-1:0] i_ca_rise,
	input wire logic [CA_W-1:0] i_ca_fall,
	input wire logic i_cs_n,
	input wire logic i_cke,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic [MASK_W-1:0] i_wmask,
	input wire logic [RADDR_W-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_rvalid,
	output logic o_wtaken,
	output logic o_idle,
	output logic o_refresh_strobe,
	output logic [BANKS-1:0] o_refresh_banks
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [CA_W-1:0] ca_r_m, ca_r, ca_f_m, ca_f;
	logic cs_n_m, cs_n, cke_m, cke;
	logic [DATA_W-1:0] wd_m, wd;
	logic [MASK_W-1:0] wm_m, wm;

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ca_r_m <= '0;
			ca_r <= '0;
			ca_f_m <= '0;
			ca_f <= '0;
			cs_n_m <= 1'h1;
			cs_n <= 1'h1;
			cke_m <= 1'h0;
			cke <= 1'h0;
			wd_m <= '0;
			wd <= '0;
			wm_m <= '0;
			wm <= '0;
		end else begin
			ca_r_m <= i_ca_rise;
			ca_f_m <= i_ca_fall;
			ca_r <= ca_r_m;
			ca_f <= ca_f_m;
			cs_n_m <= i_cs_n;
			cs_n <= cs_n_m;
			cke_m <= i_cke;
			cke <= cke_m;
			wd_m <= i_wdata;
			wd <= wd_m;
			wm_m <= i_wmask;
			wm <= wm_m;
		end
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic sel, cmd_act, cmd_wr, cmd_rd, cmd_pre, cmd_refab, cmd_refpb, cmd_rw;
	logic [BANK_W-1:0] cmd_bank;
	logic [ROW_W-1:0] cmd_row;
	logic [COL_W-1:0] cmd_col;

	assign sel = cke && !cs_n;
	assign cmd_act = sel && (ca_r[1:0] == ACT_CODE);
	assign cmd_wr = sel && (ca_r[2:0] == WR_CODE);
	assign cmd_rd = sel && (ca_r[2:0] == RD_CODE);
	assign cmd_pre = sel && (ca_r[3:0] == PRE_CODE);
	assign cmd_refab = sel && (ca_r[3:0] == REFAB_CODE);
	assign cmd_refpb = sel && (ca_r[3:0] == REFPB_CODE);
	assign cmd_rw = cmd_wr || cmd_rd;
	assign cmd_bank = ca_r[BANK_LSB +: BANK_W];
	assign cmd_row = {ca_r[ROW_HI_LSB +: ROW_W-CA_W], ca_f};
	assign cmd_col = ca_f[COL_LSB +: COL_W];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [10:0] cfg;
	logic [3:0] pasr_mask;
	logic illegal;
	logic set_illegal;
	logic x16;
	logic [BEAT_W-1:0] bl_beats;
	logic [BANKS-1:0] open;

	assign x16 = cfg[CFG_X16_BIT];

	always_comb begin
		if (cfg[CFG_BL_LSB +: 2] == BL16_CODE) begin
			bl_beats = BL16_BEATS;
		end else if (cfg[CFG_BL_LSB +: 2] == BL8_CODE) begin
			bl_beats = BL8_BEATS;
		end else begin
			bl_beats = BL4_BEATS;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cfg <= CFG_RST;
			pasr_mask <= PASR_RST;
		end else if (i_reg_wr) begin
			if (i_reg_addr == REG_CFG) begin
				cfg <= i_reg_wdata[10:0];
			end else if (i_reg_addr == REG_PASR) begin
				pasr_mask <= i_reg_wdata[3:0];
			end
		end
	end

	// A refused command arriving with the clear still leaves the flag set.
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			illegal <= 1'h0;
		end else if (set_illegal) begin
			illegal <= 1'h1;
		end else if (i_reg_wr && i_reg_addr == REG_STATUS && i_reg_wdata[STAT_ILL_BIT]) begin
			illegal <= 1'h0;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_reg_rdata <= '0;
		end else if (i_reg_rd) begin
			if (i_reg_addr == REG_CFG) begin
				o_reg_rdata <= {21'h0, cfg};
			end else if (i_reg_addr == REG_PASR) begin
				o_reg_rdata <= {28'h0, pasr_mask};
			end else if (i_reg_addr == REG_STATUS) begin
				o_reg_rdata <= {26'h0, illegal, o_idle, open};
			end else begin
				o_reg_rdata <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Bank state
	// ----------------------------------------------------------------
	lpcaf_state_t state;
	logic [BEAT_W-1:0] beat;
	logic [BANK_W-1:0] cur_bank;
	logic cur_ap, last_beat;
	logic [ROW_W-1:0] open_row [BANKS];

	assign last_beat = (state == ST_DATA) && (beat == bl_beats - 5'h01);

	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		always_ff @(posedge i_clock or posedge i_sys_rst) begin
			if (i_sys_rst) begin
				open[b] <= 1'h0;
				open_row[b] <= '0;
			end else if (cmd_act && cmd_bank == BANK_W'(b)) begin
				open[b] <= 1'h1;
				open_row[b] <= cmd_row;
			end else if (cmd_pre && (ca_r[PRE_ALL_BIT] || cmd_bank == BANK_W'(b))) begin
				open[b] <= 1'h0;
			end else if (last_beat && cur_ap && cur_bank == BANK_W'(b)) begin
				open[b] <= 1'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Burst sequencer
	// ----------------------------------------------------------------
	logic start, cur_wr;
	logic [LAT_W-1:0] lat_cnt, lat_sel;
	logic [COL_W-1:0] cur_col;
	logic [ROW_W-1:0] cur_row;

	// The controller is not trusted to activate first; a miss is refused here.
	assign start = cmd_rw && open[cmd_bank] && (state == ST_IDLE);
	assign set_illegal = (cmd_rw && !start) || cmd_refpb || (cmd_refab && (open != '0));
	assign lat_sel = cmd_wr ? cfg[CFG_WL_LSB +: LAT_W] : cfg[CFG_RL_LSB +: LAT_W];

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= ST_IDLE;
			lat_cnt <= '0;
			beat <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start) begin
						state <= ST_WAIT;
						lat_cnt <= (lat_sel == '0) ? 4'h1 : lat_sel;
					end
				end
				ST_WAIT: begin
					lat_cnt <= lat_cnt - 4'h1;
					if (lat_cnt == 4'h1) begin
						state <= ST_DATA;
						beat <= '0;
					end
				end
				ST_DATA: begin
					beat <= beat + 5'h01;
					if (last_beat) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cur_wr <= 1'h0;
			cur_ap <= 1'h0;
			cur_bank <= '0;
			cur_col <= '0;
			cur_row <= '0;
		end else if (start) begin
			cur_wr <= cmd_wr;
			cur_ap <= ca_f[AP_BIT];
			cur_bank <= cmd_bank;
			cur_col <= {cmd_col[COL_W-1:2], 2'h0};
			cur_row <= open_row[cmd_bank];
		end
	end

	// ----------------------------------------------------------------
	// Array access
	// ----------------------------------------------------------------
	lpcaf_mem_if mbus ();
	logic [3:0] beat_col;
	logic [MASK_W-1:0] lane_en;

	assign beat_col = cur_col[3:0] + beat[3:0];
	// Only a few row bits reach the small array; wider rows alias.
	assign mbus.addr = {cur_bank, cur_row[1:0], beat_col};
	assign mbus.we = (state == ST_DATA) && cur_wr;
	assign mbus.re = (state == ST_DATA) && !cur_wr;
	assign lane_en = x16 ? 4'h3 : 4'hF;
	assign mbus.be = ~wm & lane_en;
	assign mbus.wdata = wd;

	lpcaf_mem u_mem (
		.i_clock(i_clock),
		.bus(mbus.mem)
	);

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rvalid <= 1'h0;
		end else begin
			o_rvalid <= mbus.re;
		end
	end

	assign o_rdata = x16 ? {16'h0, mbus.rdata[15:0]} : mbus.rdata;
	assign o_wtaken = mbus.we;

	// ----------------------------------------------------------------
	// Refresh
	// ----------------------------------------------------------------
	logic [SREF_CNT_W-1:0] sref_cnt;
	logic sref_tick;

	// The clock may only stop here, so idle also gates self-refresh.
	assign o_idle = (state == ST_IDLE);
	assign sref_tick = !cke && o_idle && (sref_cnt == SREF_CNT_W'(SREF_CYC - 1));

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sref_cnt <= '0;
		end else if (cke || sref_tick) begin
			sref_cnt <= '0;
		end else begin
			sref_cnt <= sref_cnt + 10'h001;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_refresh_strobe <= 1'h0;
			o_refresh_banks <= '0;
		end else if (sref_tick) begin
			o_refresh_strobe <= 1'h1;
			o_refresh_banks <= ~pasr_mask;
		end else if (cmd_refab && open == '0) begin
			o_refresh_strobe <= 1'h1;
			o_refresh_banks <= 4'hF;
		end else begin
			o_refresh_strobe <= 1'h0;
			o_refresh_banks <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [BEAT_W-1:0] data_cycles;
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			data_cycles <= '0;
		end else if (state == ST_DATA) begin
			data_cycles <= data_cycles + 5'h01;
		end else begin
			data_cycles <= '0;
		end
	end

	sequence rw_start_s;
		start && cmd_rd && cfg[CFG_RL_LSB +: LAT_W] == 4'h2;
	endsequence
	sequence wait_two_s;
		(state == ST_WAIT) [*2] ##1 (state == ST_DATA);
	endsequence

	act_open_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		cmd_act |=> open[$past(cmd_bank)] && open_row[$past(cmd_bank)] == $past(cmd_row))
		else $error("activate did not open the row");
	closed_bank_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(cmd_rw && !open[cmd_bank]) |=> illegal && state == ST_IDLE)
		else $error("access to closed bank was not refused");
	burst_len_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		$fell(state == ST_DATA) |-> data_cycles == $past(bl_beats))
		else $error("burst beat count wrong");
	read_lat_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		rw_start_s |=> wait_two_s)
		else $error("read latency not honoured");
	pre_all_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(cmd_pre && ca_r[PRE_ALL_BIT] && !cmd_act) |=> open == '0)
		else $error("precharge all left a bank open");
	refpb_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		cmd_refpb |=> illegal && !(o_refresh_strobe && o_refresh_banks == 4'hF))
		else $error("per-bank refresh accepted");
	pasr_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(o_refresh_strobe && !$past(cke)) |-> (o_refresh_banks & $past(pasr_mask)) == '0)
		else $error("masked bank refreshed");
	mask_lane_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		mbus.we |-> (mbus.be & wm) == '0 && (!x16 || mbus.be[3:2] == 2'h0))
		else $error("masked or unused lane written");
	prefetch_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(state == ST_DATA) |-> (beat_col[1:0] & PREFETCH_MASK) == (beat[1:0] & PREFETCH_MASK))
		else $error("burst not aligned to four words");
	idle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		start |=> !o_idle [*2])
		else $error("idle shown during a burst");
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the command/address front end.
`default_nettype none
`define CHK(nm, ex, got) chk(nm, (got) !== (ex), 64'(ex), 64'(got))
module tb_top
	import lpcaf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [1:0] blc;
		int n;
		int rl;
		int wl;
		logic [8:0] col;
		logic x16;
	} lpcaf_row_t;
	lpcaf_row_t rows [4] = '{'{2'h0, 4, 1, 1, 9'h004, 1'b0}, '{BL8_CODE, 8, 2, 3, 9'h00E, 1'b0},
		'{BL16_CODE, 16, 5, 0, 9'h1F0, 1'b0}, '{2'h3, 4, 0, 4, 9'h002, 1'b1}};
	logic i_clock;
	logic i_sys_rst;
	logic [CA_W-1:0] i_ca_rise;
	logic [CA_W-1:0] i_ca_fall;
	logic i_cs_n;
	logic i_cke;
	logic [DATA_W-1:0] i_wdata;
	logic [MASK_W-1:0] i_wmask;
	logic [RADDR_W-1:0] i_reg_addr;
	logic [31:0] i_reg_wdata;
	logic i_reg_wr;
	logic i_reg_rd;
	logic [31:0] o_reg_rdata;
	logic [DATA_W-1:0] o_rdata;
	logic o_rvalid;
	logic o_wtaken;
	logic o_idle;
	logic o_refresh_strobe;
	logic [BANKS-1:0] o_refresh_banks;
	logic [31:0] shadow [256];
	logic [BANKS-1:0] ref_banks;
	int failures;
	int check_count;
	int ref_count;
	lpcaf_ctrl_model u_ctrl (.i_clock, .o_ca_rise(i_ca_rise), .o_ca_fall(i_ca_fall), .o_cs_n(i_cs_n),
		.o_cke(i_cke), .o_wdata(i_wdata), .o_wmask(i_wmask));
	lpcaf_top u_dut (.i_clock, .i_sys_rst, .i_ca_rise, .i_ca_fall, .i_cs_n, .i_cke, .i_wdata, .i_wmask,
		.i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_rdata, .o_rvalid, .o_wtaken, .o_idle,
		.o_refresh_strobe, .o_refresh_banks);
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		if (o_refresh_strobe === 1'b1) begin
			ref_count++;
			ref_banks = o_refresh_banks;
		end
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input bit bad, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (bad) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [RADDR_W-1:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
	endtask
	task automatic reg_chk(input string nm, input logic [RADDR_W-1:0] a, input logic [31:0] e);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clock);
		i_reg_rd <= 1'b0;
		#1;
		`CHK(nm, e, o_reg_rdata);
	endtask
	task automatic act(input logic [1:0] b, input logic [ROW_W-1:0] r);
		u_ctrl.cmd({1'b0, b, r[14:10], ACT_CODE}, r[9:0]);
	endtask
	// The monitor watches 60 cycles, so extra beats are caught and the next command finds the device idle.
	task automatic burst(input bit wr, input logic [1:0] b, input logic [1:0] r, input logic [8:0] c,
		input int lat, input int n, input logic [3:0] m, input bit x16);
		logic [31:0] d [16];
		logic [31:0] e;
		logic [MEM_AW-1:0] a;
		int first;
		int seen;
		first = 0;
		seen = 0;
		for (int k = 0; k < 16; k++) begin
			d[k] = 32'hC3A5_0000 ^ {8'(n), 6'(b), r, 8'(c), 8'(k)};
		end
		fork
			begin
				u_ctrl.cmd({1'b0, b, 4'h0, wr ? WR_CODE : RD_CODE}, {c, 1'b0});
				if (wr && n > 0) begin
					u_ctrl.wr_data(lat < 1 ? 1 : lat, n, d, m);
				end
			end
			begin
				@(posedge i_clock);
				for (int cyc = 1; cyc <= 60; cyc++) begin
					@(posedge i_clock);
					#1;
					if ((wr ? o_wtaken : o_rvalid) === 1'b1) begin
						a = {b, r, 4'({c[3:2], 2'b00} + seen)};
						if (first == 0) begin
							first = cyc;
						end
						if (wr) begin
							for (int i = 0; i < MASK_W; i++) begin
								if (!m[i] && !(x16 && i >= 2)) begin
									shadow[a][8*i +: 8] = d[seen][8*i +: 8];
								end
							end
						end else begin
							e = shadow[a];
							if (x16) begin
								e[31:16] = 16'h0000;
							end
							`CHK("read beat", e, o_rdata);
						end
						seen++;
					end
				end
			end
		join
		`CHK("beat count", n, seen);
		if (n > 0) begin
			`CHK("latency", (wr ? 3 : 4) + (lat < 1 ? 1 : lat), first);
		end
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		i_sys_rst = 1'b1;
		i_reg_addr = '0;
		i_reg_wdata = '0;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		repeat (10) @(posedge i_clock);
		#1;
		`CHK("idle in reset", 1'b1, o_idle);
		`CHK("rvalid in reset", 1'b0, o_rvalid);
		@(posedge i_clock);
		i_sys_rst <= 1'b0;
		repeat (3) @(posedge i_clock);
		reg_chk("cfg reset", REG_CFG, 32'h0000_00C4);
		reg_chk("pasr reset", REG_PASR, 32'h0000_0000);
		reg_chk("status reset", REG_STATUS, 32'h0000_0010);
		reg_wr(4'hC, 32'hFFFF_FFFF);
		reg_chk("unmapped", 4'hC, 32'h0000_0000);
		reg_chk("cfg kept", REG_CFG, 32'h0000_00C4);
		foreach (rows[i]) begin
			reg_wr(REG_CFG, 32'({rows[i].x16, 4'(rows[i].wl), 4'(rows[i].rl), rows[i].blc}));
			act(2'(i), 15'h4A00 | 15'(i));
			burst(1'b1, 2'(i), 2'(i), rows[i].col, rows[i].wl, rows[i].n, 4'h0, rows[i].x16);
			burst(1'b0, 2'(i), 2'(i), rows[i].col, rows[i].rl, rows[i].n, 4'h0, rows[i].x16);
		end
		reg_chk("all open", REG_STATUS, 32'h0000_001F);
		reg_wr(REG_CFG, 32'h0000_0044);
		burst(1'b1, 2'h0, 2'h0, 9'h005, 1, 4, 4'h5, 1'b0);
		burst(1'b0, 2'h0, 2'h0, 9'h004, 1, 4, 4'h0, 1'b0);
		u_ctrl.cmd({1'b0, 2'h1, 3'h0, PRE_CODE}, 10'h000);
		repeat (4) @(posedge i_clock);
		reg_chk("bank closed", REG_STATUS, 32'h0000_001D);
		burst(1'b0, 2'h1, 2'h1, 9'h000, 1, 0, 4'h0, 1'b0);
		burst(1'b1, 2'h1, 2'h1, 9'h000, 1, 0, 4'h0, 1'b0);
		reg_chk("illegal set", REG_STATUS, 32'h0000_003D);
		reg_wr(REG_STATUS, 32'h0000_0020);
		act(2'h1, 15'h0001);
		burst(1'b0, 2'h1, 2'h1, 9'h00C, 1, 4, 4'h0, 1'b0);
		reg_chk("illegal cleared", REG_STATUS, 32'h0000_001F);
		u_ctrl.cmd({6'h00, REFPB_CODE}, 10'h000);
		u_ctrl.cmd({6'h00, REFAB_CODE}, 10'h000);
		repeat (6) @(posedge i_clock);
		`CHK("refused refresh", 0, ref_count);
		reg_chk("refresh refused", REG_STATUS, 32'h0000_003F);
		reg_wr(REG_STATUS, 32'h0000_0020);
		u_ctrl.cmd({1'b0, 2'h2, 4'h0, RD_CODE}, 10'h001);
		repeat (12) @(posedge i_clock);
		reg_chk("auto precharge", REG_STATUS, 32'h0000_001B);
		u_ctrl.cmd({5'h00, 1'b1, PRE_CODE}, 10'h000);
		repeat (4) @(posedge i_clock);
		reg_chk("all closed", REG_STATUS, 32'h0000_0010);
		u_ctrl.cmd({6'h00, REFAB_CODE}, 10'h000);
		repeat (6) @(posedge i_clock);
		`CHK("refresh count", 1, ref_count);
		`CHK("refresh banks", 4'hF, ref_banks);
		reg_wr(REG_PASR, 32'h0000_0005);
		u_ctrl.set_cke(1'b0);
		for (int k = 0; k < 900 && ref_count < 2; k++) begin
			@(posedge i_clock);
		end
		`CHK("self refresh", 2, ref_count);
		`CHK("masked banks", 4'hA, ref_banks);
		u_ctrl.set_cke(1'b1);
		reg_chk("pasr kept", REG_PASR, 32'h0000_0005);
		@(posedge i_clock);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		repeat (3) @(posedge i_clock);
		reg_chk("status again", REG_STATUS, 32'h0000_0010);
		reg_chk("pasr again", REG_PASR, 32'h0000_0000);
		final_report();
	end
endmodule
`undef CHK
`default_nettype wire
